//--- hdl/asp_top.sv
// Configuration and pin routing for the primary and secondary audio serial ports.
// Assumes an 8-bit register port on sys_clk and pins from outside the clock domain.
// Overview of operation
// - Override set: PDM pairs selecting input_pin_1 take serial data input instead.
// - Shared bit set: serial data out pin carries both output and input data.
// - ADC powers down when selected pin or the power bit asks for it.
// - Analog bit set hands multi_pin_1 to the general purpose analog function.
// - Bias enable pin select: none, multi_pin_1, multi_pin_2 or input_pin_1.
// - Aux conversion start pin select: none, multi_pin_1, multi_pin_2 or input_pin_1.
// - Primary port enabled while its disable bit is 0; resets to 0.
// - Secondary port enabled while its disable bit is 0; resets to 1.
// - Gang bit set makes the secondary port copy primary port settings.
// - Daisy field: off, primary chained, secondary chained; chaining removes other port.
// - Daisy input source: off, three pins, serial data input; other codes reserved.
// - Output lane field: one each, two for primary, two for secondary.
// - Input lane field: one each, two for primary, two for secondary.
// - Daisy direction: 0 chains through data output, 1 through data input.
// - Frame format: TDM, I2S, left-justified; code 3 reserved.
// - Slot length 16, 20, 24 or 32 bits; resets to 32.
// - Frame sync invert bit flips frame sync polarity.
// - Bit clock invert bit flips bit clock polarity.
// - Bus fault detection runs while its bit is 0.
// - Bit 0 resumes after fault clears; bit 1 halts until host reconfigures.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "asp_cfg.svh"
module asp_top
  import asp_pkg::*;
#(
  parameter int TMO_CYC = `ASP_BCLK_TMO_CYC
) (
  input  wire logic       sys_clk,          // 250 MHz system clock
  input  wire logic       rstn,             // async reset, active low
  input  wire logic [7:0] reg_addr,         // register byte offset
  input  wire logic [7:0] reg_wdata,        // write data
  input  wire logic       reg_wr,           // write strobe
  input  wire logic       reg_rd,           // read strobe
  output logic      [7:0] reg_rdata,        // read data, cycle after read
  input  wire logic       multi_pin_1,      // pin level
  input  wire logic       multi_pin_2,      // pin level
  input  wire logic       input_pin_1,      // pin level
  input  wire logic       serial_data_in_pin, // serial input pin
  input  wire logic       sdout_pin_i,      // serial output pin, input side
  output logic            sdout_pin_o,      // serial output pin, output side
  output logic            sdout_pin_oe,     // high while driving
  input  wire logic       bit_clk_pin,      // primary bit clock
  input  wire logic       frame_sync_pin,   // primary frame sync
  input  wire logic       adc_power_bit,    // 0 forces ADC power-down
  input  wire logic [1:0] pdm_pair1_sel,    // pair 1 source select
  input  wire logic [1:0] pdm_pair2_sel,    // pair 2 source select
  input  wire logic [7:0] sec_own_cfg,      // secondary port own settings
  input  wire logic       pri_tx_data,      // primary port serial bit
  input  wire logic       pri_tx_en,        // primary port driving slot
  output logic            pri_rx_data,      // primary port input bit
  output logic            pdm_pair1_data,   // pair 1 data
  output logic            pdm_pair2_data,   // pair 2 data
  output logic            adc_powerdown,    // ADC power-down request
  output logic            analog_fn_en,     // multi_pin_1 in analog use
  output logic            bias_enable,      // mic bias supply enable
  output logic            aux_conv_start,   // one-cycle conversion start
  output logic            pri_active,       // primary port running
  output logic            sec_active,       // secondary port running
  output logic      [7:0] sec_frame_cfg,    // settings the secondary port uses
  output logic            daisy_on_pri,     // primary port chained
  output logic            daisy_on_sec,     // secondary port chained
  output logic            daisy_via_input,  // chain through data input
  output logic            daisy_data,       // chained-in data
  output logic      [1:0] pri_out_lanes,    // output lanes of primary
  output logic      [1:0] sec_out_lanes,    // output lanes of secondary
  output logic      [1:0] pri_in_lanes,     // input lanes of primary
  output logic      [1:0] sec_in_lanes,     // input lanes of secondary
  output logic            bus_fault         // fault seen now
);
  initial begin
    if (TMO_CYC < 2) $error("asp_top: TMO_CYC too small");
  end

  // Lane counts of a two-bit lane field; reserved code falls back to one each.
  function automatic logic [3:0] lane_split(input logic [1:0] f);
    unique case (f)
      2'h1:    lane_split = 4'h9;
      2'h2:    lane_split = 4'h6;
      default: lane_split = 4'h5;
    endcase
  endfunction

  logic [6:0] sync1_ff, sync2_ff;
  logic [7:0] pin_a_ff, nxt_pin_a, pin_b_ff, nxt_pin_b, en_ff, nxt_en;
  logic [7:0] lane_ff, nxt_lane, frame_ff, nxt_frame, rdata_ff, nxt_rdata;
  logic       seen_ff, nxt_seen, halt_ff, nxt_halt, aux_prev_ff, aux_pulse_ff, nxt_aux_pulse;
  logic       sdo_ff, nxt_sdo;
  logic       m1, m2, i1, sdin, sdoi, bclk_s, fs_s;
  logic       m1_dig, reconfig, det_on, fault, good, aux_lvl;
  logic [1:0] fmt, daisy;
  logic [2:0] dsel;
  logic [3:0] ol, il;

  // Only the second stage is read; the first may be metastable.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_ff <= 7'h00;
      sync2_ff <= 7'h00;
    end else begin
      sync1_ff <= {frame_sync_pin, bit_clk_pin, sdout_pin_i, serial_data_in_pin, input_pin_1,
                   multi_pin_2, multi_pin_1};
      sync2_ff <= sync1_ff;
    end
  end
  assign {fs_s, bclk_s, sdoi, sdin, i1, m2, m1} = sync2_ff;

  always_comb begin
    reconfig  = reg_wr && (reg_addr == `ASP_OFF_EN || reg_addr == `ASP_OFF_FRAME);
    nxt_pin_a = pin_a_ff;
    nxt_pin_b = pin_b_ff;
    nxt_en    = en_ff;
    nxt_lane  = lane_ff;
    nxt_frame = frame_ff;
    nxt_rdata = 8'h00;
    if (reg_wr) begin
      unique case (reg_addr)
        `ASP_OFF_PIN_A: nxt_pin_a = reg_wdata & `ASP_WM_PIN_A;
        `ASP_OFF_PIN_B: nxt_pin_b = reg_wdata & `ASP_WM_PIN_B;
        `ASP_OFF_EN:    nxt_en    = reg_wdata;
        `ASP_OFF_LANE:  nxt_lane  = reg_wdata & `ASP_WM_LANE;
        `ASP_OFF_FRAME: nxt_frame = reg_wdata;
        default:        ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `ASP_OFF_PIN_A: nxt_rdata = pin_a_ff;
        `ASP_OFF_PIN_B: nxt_rdata = pin_b_ff;
        `ASP_OFF_EN:    nxt_rdata = en_ff;
        `ASP_OFF_LANE:  nxt_rdata = lane_ff;
        `ASP_OFF_FRAME: nxt_rdata = frame_ff;
        `ASP_OFF_STAT:  nxt_rdata = {3'h0, sec_active, pri_active, halt_ff, fault, seen_ff};
        default:        nxt_rdata = 8'h00;
      endcase
    end
    // A fault in the same cycle as a write-one clear keeps the flag set.
    nxt_seen = fault |
               (seen_ff & ~(reg_wr && reg_addr == `ASP_OFF_STAT && reg_wdata[`ASP_S_SEEN]));
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_a_ff <= `ASP_RST_PIN_A;
      pin_b_ff <= `ASP_RST_PIN_B;
      en_ff    <= `ASP_RST_EN;
      lane_ff  <= `ASP_RST_LANE;
      frame_ff <= `ASP_RST_FRAME;
      rdata_ff <= 8'h00;
      seen_ff  <= 1'b0;
    end else begin
      pin_a_ff <= nxt_pin_a;
      pin_b_ff <= nxt_pin_b;
      en_ff    <= nxt_en;
      lane_ff  <= nxt_lane;
      frame_ff <= nxt_frame;
      rdata_ff <= nxt_rdata;
      seen_ff  <= nxt_seen;
    end
  end
  assign reg_rdata = rdata_ff;

  // Pin functions. In analog use multi_pin_1 reads as low to every digital select.
  always_comb begin
    analog_fn_en   = pin_a_ff[`ASP_A_ANALOG];
    m1_dig         = m1 & ~analog_fn_en;
    adc_powerdown  = ~adc_power_bit |
                     asp_pin_pick(pin_a_ff[`ASP_A_ADCPD_HI:`ASP_A_ADCPD_LO], m1_dig, m2, i1);
    bias_enable    = asp_pin_pick(pin_b_ff[`ASP_B_BIAS_HI:`ASP_B_BIAS_LO], m1_dig, m2, i1);
    aux_lvl        = asp_pin_pick(pin_b_ff[`ASP_B_AUX_HI:`ASP_B_AUX_LO], m1_dig, m2, i1);
    pdm_pair1_data = asp_pin_pick(pdm_pair1_sel, m1_dig, m2,
                                  pin_a_ff[`ASP_A_OVRD] ? sdin : i1);
    pdm_pair2_data = asp_pin_pick(pdm_pair2_sel, m1_dig, m2,
                                  pin_a_ff[`ASP_A_OVRD] ? sdin : i1);
    nxt_aux_pulse  = aux_lvl & ~aux_prev_ff;
  end

  // Port enables, chaining and lanes.
  always_comb begin
    daisy           = en_ff[`ASP_E_DAISY_HI:`ASP_E_DAISY_LO];
    daisy_on_pri    = (daisy == 2'h1);
    daisy_on_sec    = (daisy == 2'h2);
    fmt             = frame_ff[`ASP_F_FMT_HI:`ASP_F_FMT_LO];
    pri_active      = ~en_ff[`ASP_E_PDIS] & ~daisy_on_sec & ~halt_ff &
                      (fmt != ASP_FMT_RSVD);
    sec_active      = ~en_ff[`ASP_E_SDIS] & ~daisy_on_pri;
    sec_frame_cfg   = en_ff[`ASP_E_GANG] ? frame_ff : sec_own_cfg;
    daisy_via_input = lane_ff[`ASP_L_DIR];
    dsel            = en_ff[`ASP_E_DSEL_HI:`ASP_E_DSEL_LO];
    unique case (dsel)
      3'h1, 3'h2, 3'h3: daisy_data = asp_pin_pick(dsel[1:0], m1_dig, m2, i1);
      3'h5:             daisy_data = sdin;
      default:          daisy_data = 1'b0;
    endcase
    ol              = lane_split(lane_ff[`ASP_L_OUT_HI:`ASP_L_OUT_LO]);
    il              = lane_split(lane_ff[`ASP_L_IN_HI:`ASP_L_IN_LO]);
    {pri_out_lanes, sec_out_lanes} = ol;
    {pri_in_lanes, sec_in_lanes}   = il;
    pri_rx_data     = pri_active & (pin_a_ff[`ASP_A_SHARE] ? sdoi : sdin);
    nxt_sdo         = pri_active & pri_tx_en & pri_tx_data;
  end
  assign sdout_pin_oe = pri_active & pri_tx_en;
  assign sdout_pin_o  = sdo_ff;

  // Fault handling: a fault halts the port; without auto-resume only a reconfigure lifts it.
  always_comb begin
    det_on   = ~frame_ff[`ASP_F_DETOFF];
    nxt_halt = 1'b0;
    if (det_on) begin
      if (fault) begin
        nxt_halt = 1'b1;
      end else if (halt_ff & frame_ff[`ASP_F_NORESUME] & ~reconfig) begin
        nxt_halt = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      halt_ff      <= 1'b0;
      aux_prev_ff  <= 1'b0;
      aux_pulse_ff <= 1'b0;
      sdo_ff       <= 1'b0;
    end else begin
      halt_ff      <= nxt_halt;
      aux_prev_ff  <= aux_lvl;
      aux_pulse_ff <= nxt_aux_pulse;
      sdo_ff       <= nxt_sdo;
    end
  end
  assign aux_conv_start = aux_pulse_ff;
  assign bus_fault      = fault;

  asp_bus_mon #(
    .CNT_W   (4),
    .TMO_CYC (TMO_CYC)
  ) u_mon (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .en         (det_on & ~en_ff[`ASP_E_PDIS] & ~daisy_on_sec),
    .bclk       (bclk_s ^ frame_ff[`ASP_F_BCINV]),
    .fsync      (fs_s ^ frame_ff[`ASP_F_FSINV] ^ (fmt == ASP_FMT_I2S)),
    .fmt        (fmt),
    .slot_bits  (asp_slot_bits(frame_ff[`ASP_F_WLEN_HI:`ASP_F_WLEN_LO])),
    .fault      (fault),
    .good_frame (good)
  );

  a_rdata_only_after_rd: assert property (@(posedge sys_clk) disable iff (!rstn)
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside read window");
  a_adc_pd_bit: assert property (@(posedge sys_clk) disable iff (!rstn)
    !adc_power_bit |-> adc_powerdown) else $error("ADC not powered down by bit");
  a_pri_disable: assert property (@(posedge sys_clk) disable iff (!rstn)
    en_ff[`ASP_E_PDIS] |-> !pri_active && !sdout_pin_oe) else $error("primary runs while disabled");
  a_sec_chain: assert property (@(posedge sys_clk) disable iff (!rstn)
    daisy_on_pri |-> !sec_active) else $error("secondary runs during primary chain");
  a_gang_copy: assert property (@(posedge sys_clk) disable iff (!rstn)
    en_ff[`ASP_E_GANG] |-> sec_frame_cfg == frame_ff) else $error("gang not followed");
  a_fault_halts: assert property (@(posedge sys_clk) disable iff (!rstn)
    fault && det_on |=> !pri_active) else $error("port not halted on fault");
  a_no_resume: assert property (@(posedge sys_clk) disable iff (!rstn)
    halt_ff && frame_ff[`ASP_F_NORESUME] && det_on && !reconfig |=> halt_ff)
    else $error("halt lifted without reconfigure");
  a_auto_resume: assert property (@(posedge sys_clk) disable iff (!rstn)
    $fell(fault) && !frame_ff[`ASP_F_NORESUME] ##1 !fault |-> !halt_ff) else $error("no auto resume");
  a_seen_wins: assert property (@(posedge sys_clk) disable iff (!rstn)
    fault |=> seen_ff) else $error("fault flag lost");
  a_aux_pulse: assert property (@(posedge sys_clk) disable iff (!rstn)
    aux_conv_start |=> !aux_conv_start) else $error("aux start longer than one cycle");
  a_pdm_override: assert property (@(posedge sys_clk) disable iff (!rstn)
    pin_a_ff[`ASP_A_OVRD] && pdm_pair1_sel == 2'h3 |-> pdm_pair1_data == sdin)
    else $error("override not applied");
endmodule
`default_nettype wire

//--- hdl/asp_cfg.svh
// Offsets, field positions, reset values and timing for the audio serial port config block.
// Assumes an 8-bit register port with byte offsets as printed.
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH
`define ASP_OFF_PIN_A   8'h14
`define ASP_OFF_PIN_B   8'h15
`define ASP_OFF_EN      8'h18
`define ASP_OFF_LANE    8'h19
`define ASP_OFF_FRAME   8'h1A
`define ASP_OFF_STAT    8'h30
`define ASP_RST_PIN_A   8'h00
`define ASP_RST_PIN_B   8'h00
`define ASP_RST_EN      8'h40
`define ASP_RST_LANE    8'h00
`define ASP_RST_FRAME   8'h30
`define ASP_WM_PIN_A    8'hF1
`define ASP_WM_PIN_B    8'hF0
`define ASP_WM_LANE     8'hF8
`define ASP_A_OVRD      7
`define ASP_A_SHARE     6
`define ASP_A_ADCPD_HI  5
`define ASP_A_ADCPD_LO  4
`define ASP_A_ANALOG    0
`define ASP_B_BIAS_HI   7
`define ASP_B_BIAS_LO   6
`define ASP_B_AUX_HI    5
`define ASP_B_AUX_LO    4
`define ASP_E_PDIS      7
`define ASP_E_SDIS      6
`define ASP_E_GANG      5
`define ASP_E_DAISY_HI  4
`define ASP_E_DAISY_LO  3
`define ASP_E_DSEL_HI   2
`define ASP_E_DSEL_LO   0
`define ASP_L_OUT_HI    7
`define ASP_L_OUT_LO    6
`define ASP_L_IN_HI     5
`define ASP_L_IN_LO     4
`define ASP_L_DIR       3
`define ASP_F_FMT_HI    7
`define ASP_F_FMT_LO    6
`define ASP_F_WLEN_HI   5
`define ASP_F_WLEN_LO   4
`define ASP_F_FSINV     3
`define ASP_F_BCINV     2
`define ASP_F_DETOFF    1
`define ASP_F_NORESUME  0
`define ASP_S_SEEN      0
`define ASP_CLK_NS      4
`define ASP_BCLK_TMO_NS 2000
`define ASP_BCLK_TMO_CYC ((`ASP_BCLK_TMO_NS + `ASP_CLK_NS - 1) / `ASP_CLK_NS)
`endif

//--- hdl/asp_pkg.sv
// Types and helpers shared by the audio serial port config block.
// Assumes nothing beyond a SystemVerilog compiler.
package asp_pkg;
  typedef enum logic [1:0] {ASP_FMT_TDM, ASP_FMT_I2S, ASP_FMT_LJ, ASP_FMT_RSVD} asp_fmt_e;
  typedef enum logic [1:0] {ASP_PIN_NONE, ASP_PIN_M1, ASP_PIN_M2, ASP_PIN_I1} asp_pin_e;

  function automatic logic [5:0] asp_slot_bits(input logic [1:0] wlen);
    unique case (wlen)
      2'h0: asp_slot_bits = 6'h10;
      2'h1: asp_slot_bits = 6'h14;
      2'h2: asp_slot_bits = 6'h18;
      default: asp_slot_bits = 6'h20;
    endcase
  endfunction

  // Level of the pin that a two-bit select names; select 0 gives a quiet low.
  function automatic logic asp_pin_pick(input logic [1:0] sel, input logic m1, input logic m2,
                                        input logic i1);
    unique case (asp_pin_e'(sel))
      ASP_PIN_M1: asp_pin_pick = m1;
      ASP_PIN_M2: asp_pin_pick = m2;
      ASP_PIN_I1: asp_pin_pick = i1;
      default:    asp_pin_pick = 1'b0;
    endcase
  endfunction
endpackage

//--- hdl/asp_bus_mon.sv
// Frame checker for the primary port: counts bit clock edges between frame starts.
// Assumes bclk and fsync are already synchronised and polarity-corrected.
`timescale 1ns/10ps
`default_nettype none
`include "asp_cfg.svh"
module asp_bus_mon
  import asp_pkg::*;
#(
  parameter int CNT_W   = 4,
  parameter int TMO_CYC = `ASP_BCLK_TMO_CYC
) (
  input  wire logic       sys_clk,    // system clock
  input  wire logic       rstn,       // async reset, active low
  input  wire logic       en,         // checking enabled
  input  wire logic       bclk,       // bit clock level
  input  wire logic       fsync,      // frame start level, high marks a start
  input  wire logic [1:0] fmt,        // frame format
  input  wire logic [5:0] slot_bits,  // bits per slot
  output logic            fault,      // frame fault level
  output logic            good_frame  // one-cycle pulse per good frame
);
  localparam int TMO_W = $clog2(TMO_CYC + 1);
  initial begin
    if (CNT_W < 2 || TMO_CYC < 2) $error("asp_bus_mon: parameters too small");
  end

  logic             bclk_prev_ff, nxt_bclk_prev, fs_prev_ff, nxt_fs_prev, armed_ff, nxt_armed;
  logic             fault_ff, nxt_fault, good_ff, nxt_good;
  logic [5:0]       pos_ff, nxt_pos;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [TMO_W-1:0] tmo_ff, nxt_tmo;
  logic             rise, start, ok;

  always_comb begin
    rise          = bclk & ~bclk_prev_ff;
    start         = rise & fsync & ~fs_prev_ff;
    ok            = (pos_ff == 6'h00) && (fmt != ASP_FMT_RSVD) &&
                    ((fmt == ASP_FMT_TDM) ? (cnt_ff != '0) : (cnt_ff == CNT_W'(2)));
    nxt_bclk_prev = bclk;
    nxt_fs_prev   = fs_prev_ff;
    nxt_armed     = armed_ff;
    nxt_fault     = fault_ff;
    nxt_good      = 1'b0;
    nxt_pos       = pos_ff;
    nxt_cnt       = cnt_ff;
    nxt_tmo       = tmo_ff;
    if (!en) begin
      nxt_armed = 1'b0;
      nxt_fault = 1'b0;
      nxt_pos   = 6'h00;
      nxt_cnt   = '0;
      nxt_tmo   = '0;
    end else begin
      if (rise) begin
        nxt_tmo = '0;
      end else if (tmo_ff != TMO_W'(TMO_CYC - 1)) begin
        nxt_tmo = tmo_ff + TMO_W'(1);
      end else begin
        nxt_fault = 1'b1;
      end
      if (rise) begin
        nxt_fs_prev = fsync;
        if (start) begin
          if (armed_ff) begin
            nxt_fault = ~ok;
            nxt_good  = ok;
          end
          nxt_armed = 1'b1;
          nxt_pos   = 6'h01;
          nxt_cnt   = '0;
        end else if (pos_ff == slot_bits - 6'h01) begin
          nxt_pos = 6'h00;
          if (cnt_ff != '1) nxt_cnt = cnt_ff + CNT_W'(1);
        end else begin
          nxt_pos = pos_ff + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bclk_prev_ff <= 1'b0;
      fs_prev_ff   <= 1'b0;
      armed_ff     <= 1'b0;
      fault_ff     <= 1'b0;
      good_ff      <= 1'b0;
      pos_ff       <= 6'h00;
      cnt_ff       <= '0;
      tmo_ff       <= '0;
    end else begin
      bclk_prev_ff <= nxt_bclk_prev;
      fs_prev_ff   <= nxt_fs_prev;
      armed_ff     <= nxt_armed;
      fault_ff     <= nxt_fault;
      good_ff      <= nxt_good;
      pos_ff       <= nxt_pos;
      cnt_ff       <= nxt_cnt;
      tmo_ff       <= nxt_tmo;
    end
  end

  assign fault      = fault_ff;
  assign good_frame = good_ff;
endmodule
`default_nettype wire

//--- sim/asp_host_model.sv
// Host model: bit clock and a one-bit TDM frame sync for the primary port.
// Assumes the bench sets the frame length in bit clocks.
`timescale 1ns/10ps
`default_nettype none
module asp_host_model (
  input  wire logic       run,   // frames run while high
  input  wire logic [6:0] nbits, // bit clocks per frame
  output logic            bclk,  // bit clock, 32 ns
  output logic            fsync  // frame start pulse
);
  int cnt = 0;
  initial begin
    bclk = 1'b0;
    fsync = 1'b0;
  end
  // The clock stands still low between runs, as a real host does.
  always #16 bclk = run ? ~bclk : 1'b0;
  always @(negedge bclk) begin
    fsync <= (cnt == 0);
    cnt <= (cnt + 1 >= int'(nbits)) ? 0 : cnt + 1;
  end
endmodule
`default_nettype wire

//--- sim/tb_asp_top.sv
// Self-checking bench: register model, pin routing, port modes and link faults.
// Assumes asp_host_model drives the primary link and sys_clk runs at 250 MHz.
`timescale 1ns/10ps
`default_nettype none
module tb_asp_top;
  logic       sys_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0, pri_tx_data = 1'b0;
  logic       multi_pin_1 = 1'b0, multi_pin_2 = 1'b0, input_pin_1 = 1'b0, serial_data_in_pin = 1'b0;
  logic       sdout_pin_i = 1'b0, adc_power_bit = 1'b1, pri_tx_en = 1'b0, bit_clk_pin, frame_sync_pin;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, sec_own_cfg = 8'h00, reg_rdata, sec_frame_cfg, d, np, mdl [0:255];
  logic [6:0] nbits = 7'h20;
  logic [1:0] pdm_pair1_sel = 2'h0, pdm_pair2_sel = 2'h0, pri_out_lanes, sec_out_lanes, pri_in_lanes, sec_in_lanes;
  logic       sdout_pin_o, sdout_pin_oe, pri_rx_data, pdm_pair1_data, pdm_pair2_data, adc_powerdown, analog_fn_en;
  logic       bias_enable, aux_conv_start, pri_active, sec_active, daisy_on_pri, daisy_on_sec, daisy_via_input;
  logic       daisy_data, bus_fault;
  int         err_total = 0, n_compared = 0;
  localparam logic [7:0] OFFS [6] = '{8'h14, 8'h15, 8'h18, 8'h19, 8'h1A, 8'h20};
  always #2 sys_clk = ~sys_clk;
  asp_top #(.TMO_CYC(20)) asp_top_i (
    .sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .multi_pin_1, .multi_pin_2,
    .input_pin_1, .serial_data_in_pin, .sdout_pin_i, .sdout_pin_o, .sdout_pin_oe, .bit_clk_pin,
    .frame_sync_pin, .adc_power_bit, .pdm_pair1_sel, .pdm_pair2_sel, .sec_own_cfg, .pri_tx_data, .pri_tx_en,
    .pri_rx_data, .pdm_pair1_data, .pdm_pair2_data, .adc_powerdown, .analog_fn_en, .bias_enable,
    .aux_conv_start, .pri_active, .sec_active, .sec_frame_cfg, .daisy_on_pri, .daisy_on_sec,
    .daisy_via_input, .daisy_data, .pri_out_lanes, .sec_out_lanes, .pri_in_lanes, .sec_in_lanes, .bus_fault
  );
  asp_host_model asp_host_model_i (.run, .nbits, .bclk(bit_clk_pin), .fsync(frame_sync_pin));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      8'h14: wmask = 8'hF1;
      8'h15: wmask = 8'hF0;
      8'h19: wmask = 8'hF8;
      8'h18, 8'h1A: wmask = 8'hFF;
      default: wmask = 8'h00;
    endcase
  endfunction
  // Software keeps reserved bits at zero; an unmapped offset gets the raw value.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= (wmask(a) == 8'h00) ? v : (v & wmask(a));
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    mdl[a] = v & wmask(a);
  endtask
  task automatic rdchk(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, mdl[a], "register");
  endtask
  // Pins pass two synchroniser stages before any logic sees them.
  task automatic settle;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_fault(input logic v);
    for (int i = 0; i < 3000 && bus_fault !== v; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(bus_fault, v, "fault level");
    if (bus_fault !== v) complete_run();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  function automatic logic pk(input int k);
    pk = (k == 1) ? d[4] : (k == 2) ? d[3] : (k == 3) ? d[2] : 1'b0;
  endfunction
  initial begin
    void'($urandom(32'h2486));
    mdl = '{default: 8'h00};
    mdl[8'h18] = 8'h40;
    mdl[8'h1A] = 8'h30;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    foreach (OFFS[i]) rdchk(OFFS[i]);
    for (int i = 0; i < 12; i++) begin
      d = OFFS[$urandom_range(5)];
      wr(d, $urandom());
      rdchk(d);
    end
    $display("register test done");
    wr(8'h18, 8'h00);
    wr(8'h1A, 8'h02);
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 2; j++) begin
        d = $urandom();
        wr(8'h14, {j[0], 1'b0, k[1:0], 4'h0});
        pdm_pair1_sel <= k[1:0];
        pdm_pair2_sel <= ~k[1:0];
        {multi_pin_1, multi_pin_2, input_pin_1, serial_data_in_pin, adc_power_bit} <= d[4:0];
        wr(8'h15, {k[1:0], 6'h00});
        settle;
        chk(adc_powerdown, !d[0] | pk(k), "powerdown");
        chk(bias_enable, pk(k), "bias");
        chk(pdm_pair1_data, (k == 3 && j == 1) ? d[1] : pk(k), "pdm data");
        chk(pdm_pair2_data, (k == 0 && j == 1) ? d[1] : pk(3 - k), "pdm pair 2");
      end
    end
    wr(8'h14, 8'h41);
    sdout_pin_i <= 1'b1;
    serial_data_in_pin <= 1'b0;
    settle;
    chk(analog_fn_en, 1'b1, "analog");
    chk(pri_rx_data, 1'b1, "shared pin");
    multi_pin_1 <= 1'b1;
    multi_pin_2 <= 1'b0;
    wr(8'h15, 8'h60);
    settle;
    chk(bias_enable, 1'b0, "analog blocks pin");
    multi_pin_2 <= 1'b1;
    np = 8'h00;
    repeat (8) begin
      @(posedge sys_clk);
      #1;
      np = np + {7'h00, aux_conv_start};
    end
    chk(np, 8'h01, "aux start");
    $display("pin test done");
    for (int k = 0; k < 8; k++) begin
      d = $urandom();
      sec_own_cfg <= d;
      pri_tx_en <= 1'b1;
      pri_tx_data <= d[6];
      serial_data_in_pin <= d[7];
      wr(8'h18, {2'h0, k[0], k[2:1], k[0], 1'b0, k[0]});
      wr(8'h19, {k[2:1], k[2:1], k[0], 3'h0});
      settle;
      chk(daisy_on_pri, k[2:1] == 2'h1, "chain pri");
      chk(daisy_on_sec, k[2:1] == 2'h2, "chain sec");
      chk(sec_active, k[2:1] != 2'h1, "sec active");
      chk(sdout_pin_oe, k[2:1] != 2'h2, "pri drive");
      chk(sdout_pin_o, (k[2:1] != 2'h2) & d[6], "pri data out");
      chk(sec_frame_cfg, k[0] ? mdl[8'h1A] : d, "sec cfg");
      chk(pri_out_lanes, (k[2:1] == 2'h1) ? 8'h02 : 8'h01, "out lanes");
      chk(sec_out_lanes, (k[2:1] == 2'h2) ? 8'h02 : 8'h01, "sec out lanes");
      chk(pri_in_lanes, (k[2:1] == 2'h1) ? 8'h02 : 8'h01, "pri in lanes");
      chk(sec_in_lanes, (k[2:1] == 2'h2) ? 8'h02 : 8'h01, "in lanes");
      chk(daisy_via_input, k[0], "chain dir");
      chk(daisy_data, k[0] & d[7], "chain in");
    end
    wr(8'h18, 8'hC0);
    settle;
    chk({pri_active, sec_active}, 8'h00, "both off");
    $display("mode test done");
    wr(8'h18, 8'h00);
    wr(8'h1A, 8'h00);
    wait_fault(1'b1);
    chk(pri_active, 1'b0, "halt");
    run <= 1'b1;
    wait_fault(1'b0);
    chk(pri_active, 1'b1, "resume");
    nbits <= 7'h21;
    wait_fault(1'b1);
    wr(8'h1A, 8'h02);
    settle;
    chk({bus_fault, pri_active}, 8'h01, "detect off");
    wr(8'h1A, 8'h01);
    wait_fault(1'b1);
    nbits <= 7'h20;
    wait_fault(1'b0);
    chk(pri_active, 1'b0, "stay down");
    wr(8'h1A, 8'h01);
    settle;
    chk(pri_active, 1'b1, "host restart");
    $display("link test done");
    complete_run();
  end
endmodule
`default_nettype wire
